// ### pkg/flash_status_defs.vh
// constants for the flash status and protection register bank
`ifndef FLASH_STATUS_DEFS_VH
`define FLASH_STATUS_DEFS_VH
// register select codes
`define SEL_LOW 2'h0
`define SEL_MID 2'h1
`define SEL_HIGH 2'h2
// low register fields
`define BIT_BUSY 0
`define BIT_WEL 1
`define BP_LSB 2
`define BP_MSB 6
`define BIT_SP_LO 7
// mid register fields
`define BIT_SP_HI 0
`define BIT_QE 1
`define LOCK_LSB 3
`define LOCK_MSB 5
`define BIT_CMP 6
`define BIT_SUS 7
// high register fields
`define DRV_LSB 5
`define DRV_MSB 6
`define BIT_PIN_ROLE 7
// reset values and writable masks
`define LOW_RESET 8'h00
`define MID_RESET 8'h00
`define HIGH_RESET 8'h60
`define LOW_WMASK 8'hfc
`define MID_WMASK 8'h7b
`define HIGH_WMASK 8'he0
// drive strength codes
`define DRV_25 2'h0
`define DRV_100 2'h3
// operation time in cycles at 250 MHz
`define OP_TIME_US 1
`define OP_CYCLES ((`OP_TIME_US * 1000) / 4)
`endif

// ### rtl/flash_status_protect_regs.v
// status registers and write protection logic of a serial nor flash
// Operation
// [R1] busy flag high during program, erase, write
// [R2] latch flag mirrors latch; zero refuses writes
// [R3] block protect bits changed only by write
// [R4] block protect writes refused when hardware protected
// [R5] chip erase only when protect bits allow
// [R6] mode 00: writes need only latch set
// [R7] mode 01: protect pin low blocks writes
// [R8] mode 10: locked until power cycle
// [R9] mode 11: status register locked forever
// [R10] quad enable turns pins into data lines
// [R11] host avoids quad enable with tied pins
// [R12] security locks set once, never cleared
// [R13] complement bit joins block protect decoding
// [R14] suspend flag set by suspend, cleared resume
// [R15] pin role bit selects pause or reset
// [R16] quad enable disables pause and reset
// [R17] two bits select output drive strength
// [R18] delivery values zero, high register drive 11
// [R19] latch cleared by reset and write instructions
// [R20] reserved and read-only bits ignore writes
// [R21] stored bits survive resets; lockdown cleared
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_defs.vh"
module flash_status_protect_regs (
   input wire clk,
   input wire reset,
   input wire power_up,
   input wire cmd_write_enable,
   input wire cmd_write_disable,
   input wire cmd_write_status,
   input wire [1:0] cmd_sel,
   input wire [7:0] cmd_data,
   input wire cmd_program,
   input wire cmd_sector_erase,
   input wire cmd_chip_erase,
   input wire cmd_suspend,
   input wire cmd_resume,
   input wire target_protected,
   input wire protect_pin_n,
   input wire pin_role_pin_n,
   output reg [7:0] status_reg_low,
   output reg [7:0] status_reg_mid,
   output reg [7:0] status_reg_high,
   output reg op_start,
   output reg op_refused,
   output reg quad_enable,
   output reg pause_active,
   output reg pin_reset_active,
   output reg [1:0] drive_strength
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   localparam IDLE = 2'b01;
   localparam BUSY = 2'b10;
   reg [1:0] state;
   reg [15:0] count;
   wire [31:0] op_last = `OP_CYCLES - 1;
   reg write_enable_latch;
   reg suspend_flag;
   wire [23:0] nv;
   reg [7:0] next_low;
   reg [7:0] next_mid;
   reg [7:0] next_high;
   wire [7:0] low = nv[7:0];
   wire [7:0] mid = nv[15:8];
   wire [7:0] high = nv[23:16];
   wire status_protect_hi = mid[`BIT_SP_HI];
   wire status_protect_lo = low[`BIT_SP_LO];
   wire busy_flag = (state == BUSY); // [R1]

   // ----------------------------------------------------------------
   // status write permission
   // ----------------------------------------------------------------
   function sr_writable;
      input sp_hi;
      input sp_lo;
      input wp_n;
      begin
         case ({sp_hi, sp_lo})
            2'b00: sr_writable = 1'b1; // [R6]
            2'b01: sr_writable = wp_n; // [R7] [R4]
            2'b10: sr_writable = 1'b0; // [R8]
            2'b11: sr_writable = 1'b0; // [R9]
            default: sr_writable = 1'b0;
         endcase
      end
   endfunction

   function chip_erase_ok;
      input [2:0] bp;
      input cmp;
      begin
         chip_erase_ok = (bp == 3'h0 && !cmp) || (bp == 3'h7 && cmp); // [R5] [R13]
      end
   endfunction

   wire quad_now = mid[`BIT_QE];
   // in quad mode the protect pin is a data line, so it cannot block writes
   wire wp_level = quad_now ? 1'b1 : protect_pin_n; // [R10]
   wire gate = write_enable_latch && !busy_flag; // [R2]
   wire sr_ok = gate && cmd_write_status &&
      sr_writable(status_protect_hi, status_protect_lo, wp_level);
   wire ce_ok = gate && cmd_chip_erase &&
      chip_erase_ok(low[4:2], mid[`BIT_CMP]);
   wire pe_ok = gate && (cmd_program || cmd_sector_erase) && !target_protected; // [R3]
   wire any_write = cmd_write_status || cmd_program || cmd_sector_erase || cmd_chip_erase;
   wire pin_reset = !quad_now && high[`BIT_PIN_ROLE] && !pin_role_pin_n; // [R15] [R16]

   // ----------------------------------------------------------------
   // next register values
   // ----------------------------------------------------------------
   always @* begin
      next_low = low;
      next_mid = mid;
      next_high = high;
      if (power_up && status_protect_hi && !status_protect_lo) begin
         next_low[`BIT_SP_LO] = 1'b0; // [R8] [R21]
         next_mid[`BIT_SP_HI] = 1'b0;
      end else if (sr_ok) begin
         case (cmd_sel)
            `SEL_LOW: begin
               next_low = (cmd_data & `LOW_WMASK) | (low & ~`LOW_WMASK); // [R3] [R20]
            end
            `SEL_MID: begin
               next_mid = (cmd_data & `MID_WMASK) | (mid & ~`MID_WMASK); // [R20]
               next_mid[`LOCK_MSB:`LOCK_LSB] = mid[`LOCK_MSB:`LOCK_LSB] |
                  cmd_data[`LOCK_MSB:`LOCK_LSB]; // [R12]
            end
            `SEL_HIGH: begin
               next_high = (cmd_data & `HIGH_WMASK) | (high & ~`HIGH_WMASK); // [R17]
            end
            default: begin
               next_low = low;
            end
         endcase
      end
   end

   // stored bits live outside reset on purpose: they must survive it
   nv_store store (
      .clk(clk),
      .power_up(power_up),
      .wr_en(1'b1),
      .wr_data({next_high, next_mid, next_low}),
      .rd_data(nv)
   ); // [R18] [R21]

   // ----------------------------------------------------------------
   // volatile control
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (reset || power_up || pin_reset) begin
         state <= IDLE;
         count <= 16'h0000;
         write_enable_latch <= 1'b0; // [R19]
         op_start <= 1'b0;
         op_refused <= 1'b0;
      end else begin
         op_start <= 1'b0;
         op_refused <= 1'b0;
         case (state)
            IDLE: begin
               if (sr_ok || ce_ok || pe_ok) begin
                  state <= BUSY; // [R1]
                  count <= op_last[15:0];
                  op_start <= 1'b1;
               end else if (any_write) begin
                  op_refused <= 1'b1; // [R2]
               end
               if (any_write || cmd_write_disable) begin
                  write_enable_latch <= 1'b0; // [R19]
               end else if (cmd_write_enable) begin
                  write_enable_latch <= 1'b1;
               end
            end
            BUSY: begin
               if (count == 16'h0000) begin
                  state <= IDLE;
               end else begin
                  count <= count - 16'h0001;
               end
            end
            default: begin
               state <= IDLE;
            end
         endcase
      end
   end

   // suspend flag survives soft reset, cleared only by resume or power cycle
   always @(posedge clk) begin
      if (power_up || cmd_resume) begin
         suspend_flag <= 1'b0; // [R14]
      end else if (cmd_suspend) begin
         suspend_flag <= 1'b1; // [R14]
      end
   end
   initial begin
      suspend_flag = 1'b0;
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (reset) begin
         status_reg_low <= `LOW_RESET;
         status_reg_mid <= `MID_RESET;
         status_reg_high <= `HIGH_RESET;
         quad_enable <= 1'b0;
         pause_active <= 1'b0;
         pin_reset_active <= 1'b0;
         drive_strength <= `DRV_100;
      end else begin
         status_reg_low <= {low[7:2], write_enable_latch, busy_flag}; // [R1] [R2]
         status_reg_mid <= {suspend_flag, mid[6:3], 1'b0, mid[1:0]}; // [R20]
         status_reg_high <= {high[7:5], 5'h00}; // [R20]
         quad_enable <= quad_now; // [R10]
         pause_active <= !quad_now && !high[`BIT_PIN_ROLE] && !pin_role_pin_n; // [R16]
         pin_reset_active <= pin_reset; // [R15]
         drive_strength <= high[`DRV_MSB:`DRV_LSB]; // [R17]
      end
   end
endmodule // flash_status_protect_regs
`default_nettype wire

// ### rtl/nv_store.v
// non-volatile storage cells for the status bits
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_defs.vh"
module nv_store (
   input wire clk,
   input wire power_up,
   input wire wr_en,
   input wire [23:0] wr_data,
   output reg [23:0] rd_data
);
   reg [23:0] cells;
   // contents survive every reset; the owner folds the power-cycle clear into wr_data
   always @(posedge clk) begin
      if (wr_en || power_up) begin
         cells <= wr_data;
      end
      rd_data <= (wr_en || power_up) ? wr_data : cells;
   end
   // delivery values; no reset may touch these cells
   initial begin // [R18]
      cells = {`HIGH_RESET, `MID_RESET, `LOW_RESET};
      rd_data = {`HIGH_RESET, `MID_RESET, `LOW_RESET};
   end
endmodule // nv_store
`default_nettype wire

// ### tb/flash_status_protect_regs_test.sv
// self-checking bench for the status register bank
`timescale 1ns/10ps
`default_nettype none
module flash_status_protect_regs_test;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic power_up = 1'b0;
   logic target_protected = 1'b0;
   logic protect_pin_n = 1'b0;
   logic pin_role_pin_n = 1'b1;
   wire cmd_write_enable, cmd_write_disable, cmd_write_status, cmd_program, cmd_resume;
   wire cmd_sector_erase, cmd_chip_erase, cmd_suspend, op_start, op_refused;
   wire quad_enable, pause_active, pin_reset_active;
   wire [1:0] cmd_sel, drive_strength;
   wire [7:0] cmd_data, status_reg_low, status_reg_mid, status_reg_high;
   int fail_count = 0;
   int tests_run = 0;
   always #2 clk = ~clk;
   flash_status_protect_regs dut (.*);
   host_model host (.*);
   task report_and_stop;
      $display("checks %0d failures %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tick;
      @(posedge clk);
      #1;
   endtask
   task we;
      host.send(3'h0, 2'h0, 8'h00);
   endtask
   task op(input [2:0] k, input [1:0] s, input [7:0] d, input [1:0] e);
      host.send(k, s, d);
      chk({6'h00, host.ans}, {6'h00, e});
      if (e == 2'h2) begin
         tick;
         chk({7'h00, status_reg_low[0]}, 8'h01);
      end
   endtask
   task idle;
      int n;
      n = 0;
      tick;
      while (status_reg_low[0] !== 1'b0 && n < 400) begin
         tick;
         n++;
      end
      if (n == 400) begin
         fail_count++;
         report_and_stop;
      end
   endtask
   task wr(input [1:0] s, input [7:0] d);
      we;
      op(3'h2, s, d, 2'h2);
      idle;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #1;
      reset = 1'b0;
      chk({status_reg_high[7:5], status_reg_mid[2:0], drive_strength}, 8'h63);
      op(3'h2, 2'h0, 8'h1c, 2'h1);
      wr(2'h0, 8'h1f);
      chk(status_reg_low, 8'h1c);
      we;
      op(3'h5, 2'h0, 8'h00, 2'h1);
      target_protected = 1'b1;
      we;
      op(3'h3, 2'h0, 8'h00, 2'h1);
      target_protected = 1'b0;
      wr(2'h0, 8'h80);
      we;
      op(3'h2, 2'h0, 8'h84, 2'h1);
      protect_pin_n = 1'b1;
      wr(2'h0, 8'h00);
      we;
      op(3'h5, 2'h0, 8'h00, 2'h2);
      idle;
      we;
      op(3'h4, 2'h0, 8'h00, 2'h2);
      repeat (10) tick;
      host.send(3'h6, 2'h0, 8'h00);
      tick;
      chk(status_reg_mid & 8'h80, 8'h80);
      host.send(3'h7, 2'h0, 8'h00);
      tick;
      chk(status_reg_mid & 8'h80, 8'h00);
      idle;
      pin_role_pin_n = 1'b0;
      wr(2'h1, 8'h0a);
      chk({status_reg_mid[4:0], quad_enable, pause_active, pin_reset_active}, 8'h54);
      wr(2'h1, 8'h00);
      chk({status_reg_mid[4:0], quad_enable, pause_active, pin_reset_active}, 8'h42);
      pin_role_pin_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(2'h2, {1'b0, i[1:0], 5'h1f});
         chk({status_reg_high[6:0], 1'b0}, {i[1:0], 6'h00});
         chk({6'h00, drive_strength}, {6'h00, i[1:0]});
      end
      wr(2'h2, 8'he0);
      pin_role_pin_n = 1'b0;
      tick;
      chk({6'h00, pause_active, pin_reset_active}, 8'h01);
      pin_role_pin_n = 1'b1;
      tick;
      wr(2'h1, 8'h09);
      we;
      op(3'h2, 2'h1, 8'h08, 2'h1);
      power_up = 1'b1;
      tick;
      power_up = 1'b0;
      repeat (2) tick;
      chk(status_reg_mid, 8'h08);
      wr(2'h0, 8'h80);
      wr(2'h1, 8'h09);
      we;
      op(3'h2, 2'h0, 8'h00, 2'h1);
      we;
      reset = 1'b1;
      tick;
      reset = 1'b0;
      repeat (3) tick;
      chk(status_reg_low ^ status_reg_mid, 8'h89);
      report_and_stop;
   end
endmodule // flash_status_protect_regs_test
`default_nettype wire

// ### tb/fsp_check_assertions.sv
// port level checks of the status register bank
`timescale 1ns/10ps
`default_nettype none
module fsp_check (
   input wire clk,
   input wire reset,
   input wire cmd_write_status,
   input wire cmd_chip_erase,
   input wire protect_pin_n,
   input wire [7:0] status_reg_low,
   input wire [7:0] status_reg_mid,
   input wire op_start,
   input wire op_refused,
   input wire quad_enable,
   input wire pause_active,
   input wire pin_reset_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_busy; op_start |=> status_reg_low[0] [*8]; endproperty
   a_busy: assert property (p_busy) else $error("busy short");
   property p_wel; (op_start || op_refused) |=> !status_reg_low[1]; endproperty
   a_wel: assert property (p_wel) else $error("latch kept");
   property p_nolatch; cmd_write_status && !status_reg_low[1] |=> !op_start; endproperty
   a_nolatch: assert property (p_nolatch) else $error("write w/o latch");
   property p_hw; cmd_write_status && status_reg_low[7] && !status_reg_mid[0]
      && !protect_pin_n && !quad_enable |=> !op_start; endproperty
   a_hw: assert property (p_hw) else $error("pin lock");
   property p_lock; cmd_write_status && status_reg_mid[0] |=> !op_start; endproperty
   a_lock: assert property (p_lock) else $error("locked write");
   property p_chip; cmd_chip_erase && status_reg_low[4:2] != {3{status_reg_mid[6]}}
      |=> !op_start; endproperty
   a_chip: assert property (p_chip) else $error("chip erase");
   property p_otp; status_reg_mid[5:3] != 3'h0 |=>
      (status_reg_mid[5:3] | $past(status_reg_mid[5:3])) == status_reg_mid[5:3]; endproperty
   a_otp: assert property (p_otp) else $error("lock cleared");
   property p_quad; quad_enable ##1 quad_enable |-> !pause_active && !pin_reset_active;
   endproperty
   a_quad: assert property (p_quad) else $error("pin fn in quad");
endmodule // fsp_check
bind flash_status_protect_regs fsp_check chk (.*);
`default_nettype wire

// ### tb/host_model.sv
// host side that issues one instruction pulse at a time
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic clk,
   input wire logic op_start,
   input wire logic op_refused,
   output logic cmd_write_enable,
   output logic cmd_write_disable,
   output logic cmd_write_status,
   output logic cmd_program,
   output logic cmd_sector_erase,
   output logic cmd_chip_erase,
   output logic cmd_suspend,
   output logic cmd_resume,
   output logic [1:0] cmd_sel,
   output logic [7:0] cmd_data
);
   logic [7:0] c = 8'h00;
   logic [1:0] ans = 2'h0;
   assign {cmd_resume, cmd_suspend, cmd_chip_erase, cmd_sector_erase} = c[7:4];
   assign {cmd_program, cmd_write_status, cmd_write_disable, cmd_write_enable} = c[3:0];
   // quad mode is set once, while the bench holds pin_role_pin_n low
   initial begin
      cmd_sel = 2'h0;
      cmd_data = 8'h00;
   end
   // data is inverted once taken so a stale byte is never mistaken for fresh
   task send(input [2:0] k, input [1:0] s, input [7:0] d);
      @(posedge clk);
      #1;
      c = 8'h01 << k;
      cmd_sel = s;
      cmd_data = d;
      @(posedge clk);
      #1;
      ans = {op_start, op_refused};
      c = 8'h00;
      cmd_data = ~d;
   endtask
endmodule // host_model
`default_nettype wire
